/* File: bcvr_bank.v */
// Buck configuration and A voltage register bank on Avalon-MM
//
// Notes on behaviour
// [RULE1] Memory buck mode 00 follows the voltage sleep bit, 01 forces sleep, 10 forces synchronous, 11 is automatic. Here 00 is always synchronous.
// [RULE2] Peripheral buck mode uses the same coding, 01 always sleep and 10 always synchronous. Here 00 is always synchronous.
// [RULE3] I/O buck mode 11 is automatic, 00 follows the voltage register, 01 and 10 as the other bucks. Here 00 is always synchronous.
// [RULE4] Config bit 5 clear applies the pull-down while disabled; set removes it.
// [RULE5] Feedback bits 0, 1, 2 pick own output, core switch sense and peripheral switch sense independently.
// [RULE6] Software must never write zero into a feedback field.
// [RULE7] Bit 7 of an A voltage register picks synchronous (0) or sleep (1) when A settings are in use.
// [RULE8] Core buck A registers hold a 7-bit code, 0.30 V plus 10 mV per step.
// [RULE9] Processor buck A register holds a 7-bit code, 0.53 V plus 10 mV per step.
// [RULE10] Config bits 4:3 read as zero and ignore writes.
`timescale 1ns/1ns
`include "bcvr_regs.vh"
module bcvr_bank #(
	parameter ADDR_W = 10
) (
	sys_clk,
	rst,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_byteenable,
	avs_readdata,
	avs_waitrequest,
	io_sleep,
	io_sync,
	io_auto,
	io_pulldown_on,
	io_feedback_sources,
	memory_sleep,
	memory_sync,
	memory_auto,
	memory_pulldown_on,
	memory_feedback_sources,
	peripheral_sleep,
	peripheral_sync,
	peripheral_auto,
	peripheral_pulldown_on,
	peripheral_feedback_sources,
	core_two_sleep_on_a,
	core_two_target_code_a,
	core_one_sleep_on_a,
	core_one_target_code_a,
	processor_sleep_on_a,
	processor_target_code_a,
	unmapped_access
);
	input wire sys_clk;
	input wire rst;
	input wire [ADDR_W-1:0] avs_address;
	input wire avs_read;
	input wire avs_write;
	input wire [31:0] avs_writedata;
	input wire [3:0] avs_byteenable;
	output reg [31:0] avs_readdata;
	output reg avs_waitrequest;
	output wire io_sleep;
	output wire io_sync;
	output wire io_auto;
	output reg io_pulldown_on;
	output reg [2:0] io_feedback_sources;
	output wire memory_sleep;
	output wire memory_sync;
	output wire memory_auto;
	output reg memory_pulldown_on;
	output reg [2:0] memory_feedback_sources;
	output wire peripheral_sleep;
	output wire peripheral_sync;
	output wire peripheral_auto;
	output reg peripheral_pulldown_on;
	output reg [2:0] peripheral_feedback_sources;
	output reg core_two_sleep_on_a;
	output reg [6:0] core_two_target_code_a;
	output reg core_one_sleep_on_a;
	output reg [6:0] core_one_target_code_a;
	output reg processor_sleep_on_a;
	output reg [6:0] processor_target_code_a;
	output reg unmapped_access;

	// ****************************************
	// Register storage
	// ****************************************
	reg [7:0] io_buck_config_q;
	reg [7:0] memory_buck_config_q;
	reg [7:0] peripheral_buck_config_q;
	reg [7:0] core_buck_two_voltage_a_q;
	reg [7:0] core_buck_one_voltage_a_q;
	reg [7:0] processor_buck_voltage_a_q;
	reg [7:0] rd_d;
	reg hit_d;
	wire req;
	wire [7:0] wbyte;
	wire do_wr;
	// Word index is address bits 9:2; the bus sees byte address index*4
	wire [7:0] idx;

	assign idx = avs_address[ADDR_W-1:2];
	// First cycle of a request: waitrequest still high
	assign req = (avs_read | avs_write) & avs_waitrequest;
	assign wbyte = avs_writedata[7:0];
	// Write lands only at the edge where waitrequest is low
	assign do_wr = avs_write & ~avs_waitrequest & avs_byteenable[0];

	// ****************************************
	// Address decode
	// ****************************************
	always @* begin
		hit_d = 1'b1;
		if (idx == `BCVR_OFF_IO_CFG) begin
			rd_d = io_buck_config_q;
		end else if (idx == `BCVR_OFF_MEM_CFG) begin
			rd_d = memory_buck_config_q;
		end else if (idx == `BCVR_OFF_PERI_CFG) begin
			rd_d = peripheral_buck_config_q;
		end else if (idx == `BCVR_OFF_CORE2_VA) begin
			rd_d = core_buck_two_voltage_a_q;
		end else if (idx == `BCVR_OFF_CORE1_VA) begin
			rd_d = core_buck_one_voltage_a_q;
		end else if (idx == `BCVR_OFF_PRO_VA) begin
			rd_d = processor_buck_voltage_a_q;
		end else begin
			rd_d = 8'h00;
			hit_d = 1'b0;
		end
	end

	// ****************************************
	// Bus slave and register writes
	// ****************************************
	// One wait cycle per access keeps read data registered
	// Waitrequest idles high so it comes straight from a flop
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			unmapped_access <= 1'b0;
			io_buck_config_q <= `BCVR_CFG_RESET;
			memory_buck_config_q <= `BCVR_CFG_RESET;
			peripheral_buck_config_q <= `BCVR_CFG_RESET;
			core_buck_two_voltage_a_q <= `BCVR_VA_RESET;
			core_buck_one_voltage_a_q <= `BCVR_VA_RESET;
			processor_buck_voltage_a_q <= `BCVR_VA_RESET;
		end else begin
			avs_waitrequest <= ~req;
			if (req) begin
				avs_readdata <= {24'h000000, rd_d};
				unmapped_access <= ~hit_d;
			end
			if (do_wr) begin
				if (idx == `BCVR_OFF_IO_CFG) begin
					io_buck_config_q <= wbyte & `BCVR_CFG_WMASK; // [RULE10]
				end else if (idx == `BCVR_OFF_MEM_CFG) begin
					memory_buck_config_q <= wbyte & `BCVR_CFG_WMASK; // [RULE10]
				end else if (idx == `BCVR_OFF_PERI_CFG) begin
					peripheral_buck_config_q <= wbyte & `BCVR_CFG_WMASK; // [RULE10]
				end else if (idx == `BCVR_OFF_CORE2_VA) begin
					core_buck_two_voltage_a_q <= wbyte; // [RULE8]
				end else if (idx == `BCVR_OFF_CORE1_VA) begin
					core_buck_one_voltage_a_q <= wbyte; // [RULE8]
				end else if (idx == `BCVR_OFF_PRO_VA) begin
					processor_buck_voltage_a_q <= wbyte; // [RULE9]
				end
			end
		end
	end

	// ****************************************
	// Regulator controls
	// ****************************************
	// A zero feedback field is passed through as written; software must avoid it [RULE6]
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			io_pulldown_on <= 1'b1;
			memory_pulldown_on <= 1'b1;
			peripheral_pulldown_on <= 1'b1;
			io_feedback_sources <= 3'h1;
			memory_feedback_sources <= 3'h1;
			peripheral_feedback_sources <= 3'h1;
			core_two_sleep_on_a <= 1'b0;
			core_two_target_code_a <= 7'h00;
			core_one_sleep_on_a <= 1'b0;
			core_one_target_code_a <= 7'h00;
			processor_sleep_on_a <= 1'b0;
			processor_target_code_a <= 7'h00;
		end else begin
			io_pulldown_on <= ~io_buck_config_q[`BCVR_CFG_PD_OFF]; // [RULE4]
			memory_pulldown_on <= ~memory_buck_config_q[`BCVR_CFG_PD_OFF]; // [RULE4]
			peripheral_pulldown_on <= ~peripheral_buck_config_q[`BCVR_CFG_PD_OFF]; // [RULE4]
			io_feedback_sources <= io_buck_config_q[`BCVR_CFG_FB_HI:`BCVR_CFG_FB_LO]; // [RULE5]
			memory_feedback_sources <= memory_buck_config_q[`BCVR_CFG_FB_HI:`BCVR_CFG_FB_LO]; // [RULE5]
			peripheral_feedback_sources <= peripheral_buck_config_q[`BCVR_CFG_FB_HI:`BCVR_CFG_FB_LO]; // [RULE5]
			core_two_sleep_on_a <= core_buck_two_voltage_a_q[`BCVR_VA_SLEEP]; // [RULE7]
			core_two_target_code_a <= core_buck_two_voltage_a_q[`BCVR_VA_CODE_HI:`BCVR_VA_CODE_LO]; // [RULE8]
			core_one_sleep_on_a <= core_buck_one_voltage_a_q[`BCVR_VA_SLEEP]; // [RULE7]
			core_one_target_code_a <= core_buck_one_voltage_a_q[`BCVR_VA_CODE_HI:`BCVR_VA_CODE_LO]; // [RULE8]
			processor_sleep_on_a <= processor_buck_voltage_a_q[`BCVR_VA_SLEEP]; // [RULE7]
			processor_target_code_a <= processor_buck_voltage_a_q[`BCVR_VA_CODE_HI:`BCVR_VA_CODE_LO]; // [RULE9]
		end
	end

	// Memory, I/O and peripheral have no A register here, so sleep bit is tied synchronous
	bcvr_op_decode u_io (
		.sys_clk(sys_clk),
		.rst(rst),
		.op_select(io_buck_config_q[`BCVR_CFG_MODE_HI:`BCVR_CFG_MODE_LO]), // [RULE3]
		.sleep_bit(1'b0),
		.sleep_q(io_sleep),
		.sync_q(io_sync),
		.auto_q(io_auto)
	);
	bcvr_op_decode u_mem (
		.sys_clk(sys_clk),
		.rst(rst),
		.op_select(memory_buck_config_q[`BCVR_CFG_MODE_HI:`BCVR_CFG_MODE_LO]), // [RULE1]
		.sleep_bit(1'b0),
		.sleep_q(memory_sleep),
		.sync_q(memory_sync),
		.auto_q(memory_auto)
	);
	bcvr_op_decode u_peri (
		.sys_clk(sys_clk),
		.rst(rst),
		.op_select(peripheral_buck_config_q[`BCVR_CFG_MODE_HI:`BCVR_CFG_MODE_LO]), // [RULE2]
		.sleep_bit(1'b0),
		.sleep_q(peripheral_sleep),
		.sync_q(peripheral_sync),
		.auto_q(peripheral_auto)
	);
endmodule

/* File: bcvr_regs.vh */
// Register offsets, field positions and reset values of the buck configuration bank
`ifndef BCVR_REGS_VH
`define BCVR_REGS_VH
`define BCVR_OFF_IO_CFG 8'hA0
`define BCVR_OFF_MEM_CFG 8'hA1
`define BCVR_OFF_PERI_CFG 8'hA2
`define BCVR_OFF_CORE2_VA 8'hA3
`define BCVR_OFF_CORE1_VA 8'hA4
`define BCVR_OFF_PRO_VA 8'hA5
`define BCVR_CFG_MODE_HI 7
`define BCVR_CFG_MODE_LO 6
`define BCVR_CFG_PD_OFF 5
`define BCVR_CFG_FB_HI 2
`define BCVR_CFG_FB_LO 0
`define BCVR_CFG_WMASK 8'hE7
`define BCVR_VA_SLEEP 7
`define BCVR_VA_CODE_HI 6
`define BCVR_VA_CODE_LO 0
`define BCVR_MODE_BY_VREG 2'h0
`define BCVR_MODE_SLEEP 2'h1
`define BCVR_MODE_SYNC 2'h2
`define BCVR_MODE_AUTO 2'h3
`define BCVR_CFG_RESET 8'h01
`define BCVR_VA_RESET 8'h00
`define BCVR_CORE_BASE_MV 300
`define BCVR_PRO_BASE_MV 530
`define BCVR_STEP_MV 10
`endif

/* File: bcvr_op_decode.v */
// Operating mode decoder for one buck regulator
`timescale 1ns/1ns
`include "bcvr_regs.vh"
module bcvr_op_decode (
	sys_clk,
	rst,
	op_select,
	sleep_bit,
	sleep_q,
	sync_q,
	auto_q
);
	input wire sys_clk;
	input wire rst;
	input wire [1:0] op_select;
	input wire sleep_bit;
	output reg sleep_q;
	output reg sync_q;
	output reg auto_q;
	reg sleep_d;
	reg sync_d;
	reg auto_d;
	// ****************************************
	// Mode decode
	// ****************************************
	always @* begin
		sleep_d = 1'b0;
		sync_d = 1'b0;
		auto_d = 1'b0;
		case (op_select)
			`BCVR_MODE_BY_VREG: begin
				sleep_d = sleep_bit; // [RULE1] [RULE3] [RULE7]
				sync_d = ~sleep_bit; // [RULE7]
			end
			`BCVR_MODE_SLEEP: begin
				sleep_d = 1'b1; // [RULE1] [RULE2]
			end
			`BCVR_MODE_SYNC: begin
				sync_d = 1'b1; // [RULE1] [RULE2]
			end
			default: begin
				auto_d = 1'b1; // [RULE1] [RULE3]
			end
		endcase
	end
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sleep_q <= 1'b0;
			sync_q <= 1'b0;
			auto_q <= 1'b0;
		end else begin
			sleep_q <= sleep_d;
			sync_q <= sync_d;
			auto_q <= auto_d;
		end
	end
endmodule

/* File: bcvr_bank_sva.sv */
// Assertion checker for the buck configuration bank
`timescale 1ns/1ns
`include "bcvr_regs.vh"
module bcvr_bank_chk #(
	parameter ADDR_W = 10
) (
	input wire sys_clk,
	input wire rst,
	input wire [ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire io_pulldown_on,
	input wire io_auto,
	input wire [2:0] memory_feedback_sources,
	input wire memory_sleep,
	input wire memory_sync,
	input wire memory_auto,
	input wire peripheral_sleep,
	input wire peripheral_sync,
	input wire [6:0] core_two_target_code_a,
	input wire core_one_sleep_on_a,
	input wire [6:0] processor_target_code_a
);
	// ****
	// Properties
	// ****
	wire [7:0] idx = 8'(avs_address >> 2);
	wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire [7:0] wd = avs_writedata[7:0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Outputs trail the write by one edge, so checks that look three or four edges on see them settled
	a_io_pulldown: assert property (wr_ok && idx == `BCVR_OFF_IO_CFG |-> ##3 io_pulldown_on == !$past(wd[5], 3))
		else $error("io pulldown wrong");
	a_mem_feedback: assert property (wr_ok && idx == `BCVR_OFF_MEM_CFG |-> ##3 memory_feedback_sources == $past(wd[2:0], 3))
		else $error("memory feedback wrong");
	a_mem_sleep: assert property (wr_ok && idx == `BCVR_OFF_MEM_CFG && wd[7:6] == `BCVR_MODE_SLEEP |-> ##4 memory_sleep && !memory_sync && !memory_auto)
		else $error("memory forced sleep wrong");
	a_mem_by_vreg: assert property (wr_ok && idx == `BCVR_OFF_MEM_CFG && wd[7:6] == `BCVR_MODE_BY_VREG |-> ##4 memory_sync && !memory_sleep)
		else $error("memory voltage choice wrong");
	a_peri_sync: assert property (wr_ok && idx == `BCVR_OFF_PERI_CFG && wd[7:6] == `BCVR_MODE_SYNC |-> ##4 peripheral_sync && !peripheral_sleep)
		else $error("peripheral forced sync wrong");
	a_io_auto: assert property (wr_ok && idx == `BCVR_OFF_IO_CFG && wd[7:6] == `BCVR_MODE_AUTO |-> ##4 io_auto)
		else $error("io automatic wrong");
	a_core1_sleep: assert property (wr_ok && idx == `BCVR_OFF_CORE1_VA |-> ##3 core_one_sleep_on_a == $past(wd[7], 3))
		else $error("core one sleep bit wrong");
	a_core2_code: assert property (wr_ok && idx == `BCVR_OFF_CORE2_VA |-> ##3 core_two_target_code_a == $past(wd[6:0], 3))
		else $error("core two code wrong");
	a_pro_code: assert property (wr_ok && idx == `BCVR_OFF_PRO_VA |-> ##3 processor_target_code_a == $past(wd[6:0], 3))
		else $error("processor code wrong");
	a_rsvd_zero: assert property (avs_read && !avs_waitrequest && idx >= `BCVR_OFF_IO_CFG && idx <= `BCVR_OFF_PERI_CFG |-> avs_readdata[4:3] == 2'h0)
		else $error("reserved bits not zero");
endmodule
bind bcvr_bank bcvr_bank_chk #(.ADDR_W(ADDR_W)) i_chk (.*);

/* File: bcvr_bank_tb_top.sv */
// Self-checking testbench for the buck configuration bank
`timescale 1ns/1ns
`include "bcvr_regs.vh"
module bcvr_bank_tb_top;
	// ****
	// Signals and design
	// ****
	logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, unmapped_access;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic io_sleep, io_sync, io_auto, io_pulldown_on, memory_sleep, memory_sync, memory_auto, memory_pulldown_on;
	logic peripheral_sleep, peripheral_sync, peripheral_auto, peripheral_pulldown_on;
	logic [2:0] io_feedback_sources, memory_feedback_sources, peripheral_feedback_sources;
	logic core_two_sleep_on_a, core_one_sleep_on_a, processor_sleep_on_a;
	logic [6:0] core_two_target_code_a, core_one_target_code_a, processor_target_code_a;
	int n_errors = 0, n_checks = 0;
	bcvr_bank #(.ADDR_W(10)) i_dut (.*);
	initial begin
		sys_clk = 0;
		forever #2 sys_clk = ~sys_clk;
	end
	// ****
	// Tasks
	// ****
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Request held until waitrequest is seen low; data taken at that edge
	task bus(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] q);
		int k;
		@(posedge sys_clk);
		avs_address <= {i, 2'h0};
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (avs_waitrequest !== 1'h0 && k < 20);
		q = avs_readdata;
		if (k >= 20) n_errors++;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task settle;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task t_reset;
		logic [31:0] q;
		for (int i = 0; i < 6; i++) begin
			bus(0, 8'hA0 + 8'(i), 8'h00, q);
			chk("reset value", i < 3 ? `BCVR_CFG_RESET : `BCVR_VA_RESET, q);
		end
		settle;
		chk("pulldown at reset", 3'h7, {io_pulldown_on, memory_pulldown_on, peripheral_pulldown_on});
		chk("sync at reset", 3'h7, {io_sync, memory_sync, peripheral_sync});
		$display("test reset done");
	endtask
	task t_mode;
		logic [31:0] q;
		logic [7:0] d;
		for (int m = 0; m < 4; m++) begin
			// Reserved bits set on purpose; feedback field never zero
			d = {2'(m), 1'(m), 2'h3, 3'(m + 1)};
			for (int b = 0; b < 3; b++) bus(1, 8'hA0 + 8'(b), d, q);
			settle;
			chk("sleep", {3{m == 1}}, {io_sleep, memory_sleep, peripheral_sleep});
			chk("sync", {3{m == 0 || m == 2}}, {io_sync, memory_sync, peripheral_sync});
			chk("auto", {3{m == 3}}, {io_auto, memory_auto, peripheral_auto});
			chk("pulldown", {3{~d[5]}}, {io_pulldown_on, memory_pulldown_on, peripheral_pulldown_on});
			chk("feedback", {3{d[2:0]}}, {io_feedback_sources, memory_feedback_sources, peripheral_feedback_sources});
			for (int b = 0; b < 3; b++) begin
				bus(0, 8'hA0 + 8'(b), 8'h00, q);
				chk("config readback", {24'h0, d & `BCVR_CFG_WMASK}, q);
			end
		end
		$display("test mode done");
	endtask
	task t_volt;
		logic [31:0] q;
		logic [7:0] v [3];
		v = '{8'hFF, 8'h80, 8'h7F};
		for (int i = 0; i < 3; i++) bus(1, 8'hA3 + 8'(i), v[i], q);
		settle;
		chk("sleep on a", {v[0][7], v[1][7], v[2][7]}, {core_two_sleep_on_a, core_one_sleep_on_a, processor_sleep_on_a});
		chk("core codes", {v[0][6:0], v[1][6:0]}, {core_two_target_code_a, core_one_target_code_a});
		chk("processor code", v[2][6:0], processor_target_code_a);
		for (int i = 0; i < 3; i++) begin
			bus(0, 8'hA3 + 8'(i), 8'h00, q);
			chk("voltage readback", v[i], q);
		end
		$display("test voltage done");
	endtask
	task t_refuse;
		logic [31:0] q;
		avs_byteenable <= 4'h0;
		bus(1, 8'hA3, 8'h55, q);
		avs_byteenable <= 4'h1;
		bus(0, 8'hA3, 8'h00, q);
		chk("masked write", 32'h000000FF, q);
		bus(1, 8'hA6, 8'h5A, q);
		bus(0, 8'hA6, 8'h00, q);
		chk("unmapped read", 32'h0, q);
		@(negedge sys_clk);
		chk("unmapped flag", 1'h1, unmapped_access);
		bus(0, 8'hA5, 8'h00, q);
		@(negedge sys_clk);
		chk("mapped flag", 1'h0, unmapped_access);
		$display("test refuse done");
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ****
	// Sequence and watchdog
	// ****
	initial begin
		rst = 1;
		avs_read = 0;
		avs_write = 0;
		avs_address = 10'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'h0;
		t_reset;
		t_mode;
		t_volt;
		t_refuse;
		wrap_up;
	end
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_errors++;
		wrap_up;
	end
endmodule
